// ===== rsr_pkg.sv
package rsr_pkg;
    // Clock rate and link supervision times
    localparam int CLK_MHZ = 25;
    localparam int LINK_TIMEOUT_US = 1000;
    localparam int LINK_TIMEOUT_CYC = LINK_TIMEOUT_US * CLK_MHZ;
    localparam int ACT_TIMEOUT_US = 10000;
    localparam int ACT_TIMEOUT_CYC = ACT_TIMEOUT_US * CLK_MHZ;
    localparam int TMR_W = 24;

    // Station data width, one data word is 16 bits
    localparam int WORD_BITS = 16;
    localparam int DATA_WORDS = 1;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
    localparam logic [7:0] ADDR_OUT_DATA = 8'h14;
    localparam logic [7:0] ADDR_IN_DATA = 8'h18;
    localparam logic [7:0] ADDR_CYC_CNT = 8'h1C;

    // Field positions
    localparam int CTRL_OB_DIS = 0;
    localparam int ST_SUCC = 0;
    localparam int ST_RCHK = 1;
    localparam int ST_BACT = 2;
    localparam int ST_OBDIS = 3;
    localparam int IRQ_CYC = 0;
    localparam int IRQ_LINK = 1;
    localparam int IRQ_SUCC = 2;
    localparam int IRQ_W = 3;

    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Link synchroniser lanes
    localparam int LNK_CLK = 0;
    localparam int LNK_DAT = 1;
    localparam int LNK_SEL = 2;
    localparam int LNK_RET = 3;
    localparam int LNK_SUCC = 4;
    localparam int LNK_W = 5;
endpackage

// ===== rsr_ring_model.sv
`timescale 1ns/1ns
// Ring master upstream plus a data-less repeater as successor
module rsr_ring_model #(
    parameter int BITS = 16,
    parameter logic [BITS-1:0] LOOPBACK = 16'h5A3C
) (
    // Clock
    input wire logic ref_clk_in,
    // Master side of the upstream link
    output logic up_clk_out,
    output logic up_data_out,
    output logic up_sel_out,
    input wire logic ret_data_in,
    // Successor side of the outbound port
    input wire logic present_in,
    input wire logic dn_data_in,
    output logic dn_ret_out,
    output logic successor_present_sense_out
);
    logic idle_toggle = 1'b0;

    // Bit clock stands still low between frames
    initial begin
        up_clk_out = 1'b0;
        up_data_out = 1'b0;
        up_sel_out = 1'b0;
    end

    // Unplugged return line wanders, so a stale level cannot pass
    always @(posedge ref_clk_in) idle_toggle <= ~idle_toggle;
    assign dn_ret_out = present_in ? dn_data_in : idle_toggle;
    assign successor_present_sense_out = present_in;

    // One bit: levels held long enough for the station's synchroniser
    task automatic shift_bit(input logic d, input logic s, output logic r);
        @(posedge ref_clk_in);
        up_data_out <= d;
        up_sel_out <= s;
        repeat (4) @(posedge ref_clk_in);
        up_clk_out <= 1'b1;
        repeat (10) @(posedge ref_clk_in);
        r = ret_data_in;
        up_clk_out <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
    endtask

    // Loop-back word first, outputs behind it, then the end command
    task automatic run_cycle(input logic [BITS-1:0] out_w,
        output logic [BITS-1:0] in_w, output logic [BITS-1:0] lb_w);
        logic r;
        for (int i = BITS - 1; i >= 0; i--) begin
            shift_bit(LOOPBACK[i], 1'b0, r);
            in_w[i] = r;
        end
        for (int i = BITS - 1; i >= 0; i--) begin
            shift_bit(out_w[i], 1'b0, r);
            lb_w[i] = r;
        end
        shift_bit(1'b1, 1'b1, r);
        @(posedge ref_clk_in);
        up_sel_out <= 1'b0;
        up_data_out <= 1'b0;
    endtask
endmodule

// ===== rsr_station.sv
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module rsr_station #(
    parameter int DATA_BITS = rsr_pkg::WORD_BITS * rsr_pkg::DATA_WORDS,
    parameter int LINK_TIMEOUT = rsr_pkg::LINK_TIMEOUT_CYC,
    parameter int ACT_TIMEOUT = rsr_pkg::ACT_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // Upstream link
    input wire logic up_clk_in,
    input wire logic up_data_in,
    input wire logic up_sel_in,
    output logic ret_data_out,
    // Downstream link
    output logic dn_clk_out,
    output logic dn_data_out,
    output logic dn_sel_out,
    input wire logic dn_ret_in,
    input wire logic successor_present_sense_in,
    // Periphery
    input wire logic [DATA_BITS-1:0] periph_in,
    output logic [DATA_BITS-1:0] periph_out,
    // Indicators and interrupt
    output logic bus_active_out,
    output logic remote_check_out,
    output logic outbound_disabled_out,
    output logic irq_out,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int IW = rsr_pkg::IRQ_W;
    localparam int TW = rsr_pkg::TMR_W;

    // Synchronised pins
    logic [rsr_pkg::LNK_W-1:0] lnk_raw;
    logic [rsr_pkg::LNK_W-1:0] lnk_s;
    logic [DATA_BITS-1:0] pin_s;

    assign lnk_raw = {successor_present_sense_in, dn_ret_in, up_sel_in,
                      up_data_in, up_clk_in};

    rsr_sync #(.WIDTH(rsr_pkg::LNK_W)) u_lnk_sync (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .async_in(lnk_raw),
        .sync_out(lnk_s)
    );

    rsr_sync #(.WIDTH(DATA_BITS)) u_pin_sync (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .async_in(periph_in),
        .sync_out(pin_s)
    );

    // Link state
    logic clk_prev_reg, clk_prev_next;
    logic [DATA_BITS-1:0] shreg_reg, shreg_next;
    logic [DATA_BITS-1:0] out_reg, out_next;
    logic dn_clk_reg, dn_clk_next;
    logic dn_data_reg, dn_data_next;
    logic dn_sel_reg, dn_sel_next;
    logic ret_reg, ret_next;
    logic [TW-1:0] link_tmr_reg, link_tmr_next;
    logic [TW-1:0] act_tmr_reg, act_tmr_next;
    logic rchk_reg, rchk_next;
    logic bact_reg, bact_next;
    logic obdis_reg, obdis_next;
    logic succ_prev_reg, succ_prev_next;
    logic [15:0] cyc_cnt_reg, cyc_cnt_next;
    logic shift_edge, cyc_end, ob_off, out_bit;

    // Register file state
    logic [31:0] ctrl_reg, ctrl_next;
    logic [IW-1:0] irq_stat_reg, irq_stat_next;
    logic [IW-1:0] irq_en_reg, irq_en_next;
    logic [IW-1:0] irq_set, irq_clr;
    logic irq_reg, irq_next;

    // Upstream shift and cycle-end handling
    always_comb begin
        shift_edge = lnk_s[rsr_pkg::LNK_CLK] & ~clk_prev_reg;
        // Control bit with data one marks end of cycle
        cyc_end = shift_edge & lnk_s[rsr_pkg::LNK_SEL]
            & lnk_s[rsr_pkg::LNK_DAT];
        // Missing strap also forces the outbound side off
        ob_off = ctrl_reg[rsr_pkg::CTRL_OB_DIS]
            | ~lnk_s[rsr_pkg::LNK_SUCC];
        out_bit = lnk_s[rsr_pkg::LNK_SEL] ? lnk_s[rsr_pkg::LNK_DAT]
                                          : shreg_reg[DATA_BITS-1];
        clk_prev_next = lnk_s[rsr_pkg::LNK_CLK];
        shreg_next = shreg_reg;
        out_next = out_reg;
        cyc_cnt_next = cyc_cnt_reg;
        dn_data_next = ob_off ? 1'b0 : dn_data_reg;
        ret_next = ret_reg;
        if (shift_edge && !lnk_s[rsr_pkg::LNK_SEL]) begin
            // Fixed length, position alone identifies the data
            shreg_next = {shreg_reg[DATA_BITS-2:0],
                          lnk_s[rsr_pkg::LNK_DAT]};
        end
        if (cyc_end) begin
            out_next = shreg_reg;
            shreg_next = pin_s;
            cyc_cnt_next = cyc_cnt_reg + 16'h0001;
        end
        if (shift_edge && !ob_off) begin
            dn_data_next = out_bit;
        end
        // Loop back while the outbound side is off, else relay the return line
        if (ob_off) begin
            if (shift_edge) begin
                ret_next = out_bit;
            end
        end else begin
            ret_next = lnk_s[rsr_pkg::LNK_RET];
        end
        dn_clk_next = ob_off ? 1'b0 : lnk_s[rsr_pkg::LNK_CLK];
        dn_sel_next = ob_off ? 1'b0 : lnk_s[rsr_pkg::LNK_SEL];
    end

    // Link supervision timers
    always_comb begin
        link_tmr_next = link_tmr_reg;
        act_tmr_next = act_tmr_reg;
        if (shift_edge) begin
            link_tmr_next = '0;
        end else if (link_tmr_reg < TW'(LINK_TIMEOUT)) begin
            link_tmr_next = link_tmr_reg + 1'b1;
        end
        if (cyc_end) begin
            act_tmr_next = '0;
        end else if (act_tmr_reg < TW'(ACT_TIMEOUT)) begin
            act_tmr_next = act_tmr_reg + 1'b1;
        end
        // Timers start expired, so link check and bus active are dark after reset
        rchk_next = link_tmr_reg < TW'(LINK_TIMEOUT);
        bact_next = act_tmr_reg < TW'(ACT_TIMEOUT);
        obdis_next = ob_off;
        succ_prev_next = lnk_s[rsr_pkg::LNK_SUCC];
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            clk_prev_reg <= 1'b0;
            shreg_reg <= '0;
            out_reg <= '0;
            dn_clk_reg <= 1'b0;
            dn_data_reg <= 1'b0;
            dn_sel_reg <= 1'b0;
            ret_reg <= 1'b0;
            link_tmr_reg <= TW'(LINK_TIMEOUT);
            act_tmr_reg <= TW'(ACT_TIMEOUT);
            rchk_reg <= 1'b0;
            bact_reg <= 1'b0;
            obdis_reg <= 1'b1;
            succ_prev_reg <= 1'b0;
            cyc_cnt_reg <= 16'h0000;
        end else begin
            clk_prev_reg <= clk_prev_next;
            shreg_reg <= shreg_next;
            out_reg <= out_next;
            dn_clk_reg <= dn_clk_next;
            dn_data_reg <= dn_data_next;
            dn_sel_reg <= dn_sel_next;
            ret_reg <= ret_next;
            link_tmr_reg <= link_tmr_next;
            act_tmr_reg <= act_tmr_next;
            rchk_reg <= rchk_next;
            bact_reg <= bact_next;
            obdis_reg <= obdis_next;
            succ_prev_reg <= succ_prev_next;
            cyc_cnt_reg <= cyc_cnt_next;
        end
    end

    // AXI4-Lite slave state
    logic aw_hold_reg, aw_hold_next;
    logic [7:0] awaddr_reg, awaddr_next;
    logic w_hold_reg, w_hold_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic do_wr;

    // Write and read channels, write address and data in either order
    always_comb begin
        aw_hold_next = aw_hold_reg;
        awaddr_next = awaddr_reg;
        w_hold_next = w_hold_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        ctrl_next = ctrl_reg;
        irq_en_next = irq_en_reg;
        irq_clr = '0;
        if (s_axi_awvalid && awready_reg) begin
            aw_hold_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg) begin
            w_hold_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        do_wr = aw_hold_reg && w_hold_reg && !bvalid_reg;
        if (do_wr) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = rsr_pkg::RESP_OKAY;
            unique case (awaddr_reg)
                rsr_pkg::ADDR_CTRL: begin
                    if (wstrb_reg[0]) begin
                        ctrl_next[7:0] = wdata_reg[7:0];
                    end
                end
                rsr_pkg::ADDR_IRQ_CLR: begin
                    irq_clr = wstrb_reg[0] ? wdata_reg[IW-1:0] : '0;
                end
                rsr_pkg::ADDR_IRQ_EN: begin
                    if (wstrb_reg[0]) begin
                        irq_en_next = wdata_reg[IW-1:0];
                    end
                end
                rsr_pkg::ADDR_STATUS, rsr_pkg::ADDR_IRQ_STAT,
                rsr_pkg::ADDR_OUT_DATA, rsr_pkg::ADDR_IN_DATA,
                rsr_pkg::ADDR_CYC_CNT: begin
                    bresp_next = rsr_pkg::RESP_OKAY;
                end
                default: begin
                    bresp_next = rsr_pkg::RESP_SLVERR;
                end
            endcase
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (s_axi_arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next = rsr_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                rsr_pkg::ADDR_CTRL: rdata_next = ctrl_reg;
                rsr_pkg::ADDR_STATUS: begin
                    rdata_next = '0;
                    rdata_next[rsr_pkg::ST_SUCC] = lnk_s[rsr_pkg::LNK_SUCC];
                    rdata_next[rsr_pkg::ST_RCHK] = rchk_reg;
                    rdata_next[rsr_pkg::ST_BACT] = bact_reg;
                    rdata_next[rsr_pkg::ST_OBDIS] = obdis_reg;
                end
                rsr_pkg::ADDR_IRQ_STAT: rdata_next = 32'(irq_stat_reg);
                rsr_pkg::ADDR_IRQ_EN: rdata_next = 32'(irq_en_reg);
                rsr_pkg::ADDR_OUT_DATA: rdata_next = 32'(out_reg);
                rsr_pkg::ADDR_IN_DATA: rdata_next = 32'(pin_s);
                rsr_pkg::ADDR_CYC_CNT: rdata_next = 32'(cyc_cnt_reg);
                rsr_pkg::ADDR_IRQ_CLR: rdata_next = '0;
                default: begin
                    rdata_next = '0;
                    rresp_next = rsr_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        // One write and one read in flight at most
        awready_next = !aw_hold_next && !bvalid_next;
        wready_next = !w_hold_next && !bvalid_next;
        arready_next = !rvalid_next;
    end

    // Sticky events; a set in the clear cycle is kept
    always_comb begin
        irq_set = '0;
        irq_set[rsr_pkg::IRQ_CYC] = cyc_end;
        irq_set[rsr_pkg::IRQ_LINK] = rchk_reg & ~rchk_next;
        irq_set[rsr_pkg::IRQ_SUCC] = succ_prev_reg
            ^ lnk_s[rsr_pkg::LNK_SUCC];
        irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
        irq_next = |(irq_stat_next & irq_en_next);
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            aw_hold_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            w_hold_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= rsr_pkg::RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= rsr_pkg::RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
            ctrl_reg <= rsr_pkg::CTRL_RST;
            irq_stat_reg <= '0;
            irq_en_reg <= rsr_pkg::IRQ_EN_RST;
            irq_reg <= 1'b0;
        end else begin
            aw_hold_reg <= aw_hold_next;
            awaddr_reg <= awaddr_next;
            w_hold_reg <= w_hold_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            ctrl_reg <= ctrl_next;
            irq_stat_reg <= irq_stat_next;
            irq_en_reg <= irq_en_next;
            irq_reg <= irq_next;
        end
    end

    // Outputs, all from flops
    assign ret_data_out = ret_reg;
    assign dn_clk_out = dn_clk_reg;
    assign dn_data_out = dn_data_reg;
    assign dn_sel_out = dn_sel_reg;
    assign periph_out = out_reg;
    assign bus_active_out = bact_reg;
    assign remote_check_out = rchk_reg;
    assign outbound_disabled_out = obdis_reg;
    assign irq_out = irq_reg;
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
endmodule

// ===== rsr_station_props.sv
`timescale 1ns/1ns
// Watches the link, indicator and periphery ports of one station
module rsr_station_props #(
    parameter int DATA_BITS = 16,
    parameter int LINK_TIMEOUT = 50,
    parameter int ACT_TIMEOUT = 200
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // Link pins
    input wire logic up_clk_in,
    input wire logic up_data_in,
    input wire logic up_sel_in,
    input wire logic ret_data_out,
    input wire logic dn_clk_out,
    input wire logic dn_data_out,
    input wire logic dn_sel_out,
    input wire logic dn_ret_in,
    input wire logic successor_present_sense_in,
    // Periphery and indicators
    input wire logic [DATA_BITS-1:0] periph_out,
    input wire logic bus_active_out,
    input wire logic remote_check_out,
    input wire logic outbound_disabled_out
);
    int link_idle;
    int act_idle;
    logic clk_q;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    // Idle counters saturate, so a long quiet spell cannot wrap
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            clk_q <= 1'b0;
            link_idle <= 0;
            act_idle <= 0;
        end else begin
            clk_q <= up_clk_in;
            link_idle <= (up_clk_in && !clk_q) ? 0 :
                link_idle + int'(link_idle < 4096);
            act_idle <= (up_sel_in && up_data_in) ? 0 :
                act_idle + int'(act_idle < 4096);
        end
    end

    property p_obdis;
        !successor_present_sense_in [*4] |=> outbound_disabled_out;
    endproperty
    a_obdis: assert property (p_obdis)
        else $error("outbound port live without successor strap");

    property p_dn_quiet;
        outbound_disabled_out [*3] |-> !dn_clk_out && !dn_data_out
            && !dn_sel_out;
    endproperty
    a_dn_quiet: assert property (p_dn_quiet)
        else $error("outbound lines driven while disabled");

    property p_fwd;
        $rose(up_clk_in) && !outbound_disabled_out |-> ##[1:5] dn_clk_out;
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("bit clock not forwarded downstream");

    property p_ret;
        !outbound_disabled_out [*6] |-> ret_data_out == $past(dn_ret_in, 3);
    endproperty
    a_ret: assert property (p_ret)
        else $error("return line not passed upstream");

    property p_hold;
        !up_sel_in [*8] |=> $stable(periph_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("outputs changed without cycle end");

    property p_rc_up;
        $rose(up_clk_in) |-> ##[1:8] remote_check_out;
    endproperty
    a_rc_up: assert property (p_rc_up)
        else $error("link check not lit on upstream activity");

    property p_rc_to;
        link_idle > LINK_TIMEOUT + 8 |-> !remote_check_out;
    endproperty
    a_rc_to: assert property (p_rc_to)
        else $error("link check lit on a silent link");

    property p_ba_to;
        act_idle > ACT_TIMEOUT + 8 |-> !bus_active_out;
    endproperty
    a_ba_to: assert property (p_ba_to)
        else $error("bus active lit with no cycles");

    property p_ba_on;
        $changed(periph_out) |-> ##[0:2] bus_active_out;
    endproperty
    a_ba_on: assert property (p_ba_on)
        else $error("outputs latched but bus not active");
endmodule

bind rsr_station rsr_station_props #(
    .DATA_BITS(DATA_BITS),
    .LINK_TIMEOUT(LINK_TIMEOUT),
    .ACT_TIMEOUT(ACT_TIMEOUT)
) u_props (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .up_clk_in(up_clk_in),
    .up_data_in(up_data_in),
    .up_sel_in(up_sel_in),
    .ret_data_out(ret_data_out),
    .dn_clk_out(dn_clk_out),
    .dn_data_out(dn_data_out),
    .dn_sel_out(dn_sel_out),
    .dn_ret_in(dn_ret_in),
    .successor_present_sense_in(successor_present_sense_in),
    .periph_out(periph_out),
    .bus_active_out(bus_active_out),
    .remote_check_out(remote_check_out),
    .outbound_disabled_out(outbound_disabled_out)
);

// ===== rsr_station_test.sv
`timescale 1ns/1ns
// Ring frames through the model, registers over AXI4-Lite
module rsr_station_test;
    localparam int LINK_TO = 300;
    localparam int ACT_TO = 600;
    localparam int LIMIT = 20000;
    localparam logic [15:0] LOOP_WORD = 16'h5A3C;
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic present = 1'b0;
    logic up_clk, up_data, up_sel, ret_data, dn_clk, dn_data, dn_sel;
    logic dn_ret, strap, bus_active, remote_check, ob_dis, irq;
    logic [15:0] periph_in = 16'h0000;
    logic [15:0] periph_out, in_w, lb_w;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int mismatches = 0;
    int total_checks = 0;

    rsr_station #(.LINK_TIMEOUT(LINK_TO), .ACT_TIMEOUT(ACT_TO)) dut (
        .ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
        .up_clk_in(up_clk), .up_data_in(up_data), .up_sel_in(up_sel),
        .ret_data_out(ret_data), .dn_clk_out(dn_clk),
        .dn_data_out(dn_data), .dn_sel_out(dn_sel), .dn_ret_in(dn_ret),
        .successor_present_sense_in(strap), .periph_in(periph_in),
        .periph_out(periph_out), .bus_active_out(bus_active),
        .remote_check_out(remote_check), .outbound_disabled_out(ob_dis),
        .irq_out(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    rsr_ring_model #(.BITS(16), .LOOPBACK(LOOP_WORD)) m (
        .ref_clk_in(ref_clk_in), .up_clk_out(up_clk),
        .up_data_out(up_data), .up_sel_out(up_sel),
        .ret_data_in(ret_data), .present_in(present),
        .dn_data_in(dn_data), .dn_ret_out(dn_ret),
        .successor_present_sense_out(strap)
    );

    // Free-running 25 MHz clock
    initial begin
        forever #20 ref_clk_in = ~ref_clk_in;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        @(posedge ref_clk_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge ref_clk_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        chk(bresp, er);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er);
        @(posedge ref_clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge ref_clk_in);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        chk(rresp, er);
        if (er === rsr_pkg::RESP_OKAY) chk(rdata, e);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Hang guard, well above the longest expected run
    initial begin
        repeat (LIMIT) @(posedge ref_clk_in);
        mismatches++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        rd(rsr_pkg::ADDR_STATUS, 32'h0000_0008, 2'h0);
        rd(rsr_pkg::ADDR_CTRL, rsr_pkg::CTRL_RST, 2'h0);
        rd(rsr_pkg::ADDR_IRQ_EN, 32'h0000_0000, 2'h0);
        rd(8'h20, 32'h0000_0000, rsr_pkg::RESP_SLVERR);
        wr(8'h20, 32'h0000_0001, rsr_pkg::RESP_SLVERR);
        // Two frames with the ring closed inside the station
        periph_in <= 16'hC3A5;
        m.run_cycle(16'h1234, in_w, lb_w);
        chk(periph_out, 32'h0000_1234);
        chk(lb_w, LOOP_WORD);
        periph_in <= 16'h0F1E;
        m.run_cycle(16'hABCD, in_w, lb_w);
        chk(in_w, 16'hC3A5);
        chk(periph_out, 16'hABCD);
        rd(rsr_pkg::ADDR_OUT_DATA, 32'h0000_ABCD, 2'h0);
        rd(rsr_pkg::ADDR_IN_DATA, 32'h0000_0F1E, 2'h0);
        rd(rsr_pkg::ADDR_CYC_CNT, 32'h0000_0002, 2'h0);
        rd(rsr_pkg::ADDR_STATUS, 32'h0000_000E, 2'h0);
        rd(rsr_pkg::ADDR_IRQ_STAT, 32'h0000_0001, 2'h0);
        // Interrupt masked, enabled, then cleared
        chk(irq, 1'b0);
        wr(rsr_pkg::ADDR_IRQ_EN, 32'h0000_0001, 2'h0);
        repeat (3) @(posedge ref_clk_in);
        chk(irq, 1'b1);
        rd(rsr_pkg::ADDR_IRQ_EN, 32'h0000_0001, 2'h0);
        wr(rsr_pkg::ADDR_IRQ_CLR, 32'h0000_0001, 2'h0);
        repeat (3) @(posedge ref_clk_in);
        chk(irq, 1'b0);
        rd(rsr_pkg::ADDR_IRQ_CLR, 32'h0000_0000, 2'h0);
        // Silent link: link check, then bus active, go dark
        repeat (LINK_TO + 20) @(posedge ref_clk_in);
        chk(remote_check, 1'b0);
        rd(rsr_pkg::ADDR_IRQ_STAT, 32'h0000_0002, 2'h0);
        repeat (ACT_TO) @(posedge ref_clk_in);
        chk(bus_active, 1'b0);
        rd(rsr_pkg::ADDR_STATUS, 32'h0000_0008, 2'h0);
        // Successor plugged in: frame crosses the outbound port
        present <= 1'b1;
        repeat (8) @(posedge ref_clk_in);
        chk(ob_dis, 1'b0);
        rd(rsr_pkg::ADDR_IRQ_STAT, 32'h0000_0006, 2'h0);
        m.run_cycle(16'h5AA5, in_w, lb_w);
        chk(in_w, 16'h0F1E);
        chk(lb_w, LOOP_WORD);
        chk(periph_out, 16'h5AA5);
        // Software switch-off overrides a present successor
        wr(rsr_pkg::ADDR_CTRL, 32'h0000_0001, 2'h0);
        repeat (3) @(posedge ref_clk_in);
        chk(ob_dis, 1'b1);
        rd(rsr_pkg::ADDR_CTRL, 32'h0000_0001, 2'h0);
        wr(rsr_pkg::ADDR_CTRL, 32'h0000_0000, 2'h0);
        conclude();
    end
endmodule

// ===== rsr_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser; first stage feeds only the second
module rsr_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // Next values of both stages
    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    // Stage registers
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule
